//--- design/awsr_regs.sv
// watchdog, status, result and scan-selection registers behind an ahb-lite slave
//
// Contract
// - aux sample code picks 4..384 cycles
// - watch select codes: 0-27, vref, temp
// - overrun when result unread by dma
// - overrun cleared by zero write, power-down
// - alarm when value outside window
// - alarm cleared by zero write, power-down
// - done flag at end, scan's last
// - done cleared: zero write, low read, power-down
// - result high right aligned per depth
// - result low right aligned per depth
// - reserved status/high bits read zero
// - thresholds split high/low, read/write
// - threshold bits used per depth
// - dma bypass bit disables dma; a request already pending still waits for dma_ack
// - scan bits for channels 24-27, vref, temp
// - medium density: only channel 24 exists
// - depth code: 12, 10, 8, 6 bits
// - power bit cleared means power-down
// - flag with enable raises interrupt
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "awsr_cfg.svh"

module awsr_regs
   import awsr_pkg::*;
#(
   parameter bit MEDIUM_DENSITY = 1'b0
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // converter events
   input  wire logic        conv_done,
   input  wire logic [4:0]  conv_channel,
   input  wire logic [11:0] conv_result,
   input  wire logic        scan_active,
   input  wire logic        scan_last,
   // dma
   input  wire logic        dma_ack,
   output logic             dma_request,
   output logic             dma_bypass,
   // converter configuration
   output logic             converter_power_on,
   output logic [1:0]       bit_depth_select,
   output logic [8:0]       aux_sample_cycles,
   output logic [4:0]       watch_channel_select,
   output logic             watch_channel_valid,
   output logic [3:0]       scan_channel_bits,
   output logic             scan_internal_reference,
   output logic             scan_temp_channel,
   output logic [11:0]      result_value,
   output logic             irq_request
);

   // ==========================================
   // storage
   logic [7:0]  ctrl_ff;
   logic [7:0]  wsc_ff;
   logic [3:0]  uhi_ff;
   logic [7:0]  ulo_ff;
   logic [3:0]  lhi_ff;
   logic [7:0]  llo_ff;
   logic [7:0]  scan_ff;
   awsr_value_t res_ff;
   logic        eoc_ff;
   logic        awd_ff;
   logic        ovr_ff;
   logic        pend_ff;
   logic        irq_ff;
   logic [8:0]  smp_ff;
   logic        wr_pend_ff;
   logic        rd_pend_ff;
   logic [5:0]  addr_ff;
   logic [31:0] hrdata_ff;

   logic        take;
   logic        pdn;
   logic        flg_wr;
   logic        low_rd;
   logic [7:0]  rd_mux;
   logic [7:0]  scan_mask;
   awsr_value_t depth_mask;
   awsr_value_t conv_masked;
   awsr_value_t up_lim;
   awsr_value_t lo_lim;
   logic        watch_hit;
   logic        eoc_set;
   logic        eoc_clr;
   logic        awd_clr;
   logic        ovr_set;
   logic        ovr_clr;
   logic        nxt_eoc;
   logic        nxt_awd;
   logic        nxt_ovr;
   logic        nxt_pend;
   logic [8:0]  nxt_smp;

   // ==========================================
   // bus slave
   // reads take one wait state so a write landing on the same edge is seen
   assign take      = hsel && htrans[1] && hready;
   assign hreadyout = !rd_pend_ff;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 6'h00;
         hrdata_ff  <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= take && hwrite;
         rd_pend_ff <= take && !hwrite;
         if (take) begin
            addr_ff <= haddr[7:2];
         end
         if (rd_pend_ff) begin
            hrdata_ff <= {24'h00_0000, rd_mux};
         end
      end
   end

   // reserved and unmapped bits answer zero
   always_comb begin
      unique case (addr_ff)
         `AWSR_IDX_CTRL: rd_mux = ctrl_ff;
         `AWSR_IDX_WSC:  rd_mux = wsc_ff;
         `AWSR_IDX_FLG:  rd_mux = {5'h00, ovr_ff, awd_ff, eoc_ff};
         `AWSR_IDX_RH:   rd_mux = {4'h0, res_ff[11:8]};
         `AWSR_IDX_RL:   rd_mux = res_ff[7:0];
         `AWSR_IDX_UHI:  rd_mux = {4'h0, uhi_ff};
         `AWSR_IDX_ULO:  rd_mux = ulo_ff;
         `AWSR_IDX_LHI:  rd_mux = {4'h0, lhi_ff};
         `AWSR_IDX_LLO:  rd_mux = llo_ff;
         `AWSR_IDX_SCAN: rd_mux = scan_ff;
         default:        rd_mux = 8'h00;
      endcase
   end

   // ==========================================
   // configuration registers
   // medium density has no channels 25-27, bit 6 is reserved
   assign scan_mask = MEDIUM_DENSITY ? 8'hB1 : 8'hBF;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= `AWSR_RST_CTRL;
         wsc_ff  <= `AWSR_RST_WSC;
         uhi_ff  <= `AWSR_RST_UHI;
         ulo_ff  <= `AWSR_RST_ULO;
         lhi_ff  <= `AWSR_RST_LHI;
         llo_ff  <= `AWSR_RST_LLO;
         scan_ff <= `AWSR_RST_SCAN;
      end else if (wr_pend_ff) begin
         unique case (addr_ff)
            `AWSR_IDX_CTRL: ctrl_ff <= hwdata[7:0];
            `AWSR_IDX_WSC:  wsc_ff  <= hwdata[7:0];
            `AWSR_IDX_UHI:  uhi_ff  <= hwdata[3:0];
            `AWSR_IDX_ULO:  ulo_ff  <= hwdata[7:0];
            `AWSR_IDX_LHI:  lhi_ff  <= hwdata[3:0];
            `AWSR_IDX_LLO:  llo_ff  <= hwdata[7:0];
            `AWSR_IDX_SCAN: scan_ff <= hwdata[7:0] & scan_mask;
            default: ;
         endcase
      end
   end

   assign converter_power_on      = ctrl_ff[`AWSR_CTRL_PON];
   assign bit_depth_select        = ctrl_ff[`AWSR_CTRL_RES];
   assign pdn                     = !ctrl_ff[`AWSR_CTRL_PON];
   assign watch_channel_select    = wsc_ff[`AWSR_WSC_CHAN];
   assign dma_bypass              = scan_ff[`AWSR_SCAN_DMAOF];
   assign scan_channel_bits       = scan_ff[3:0];
   assign scan_internal_reference = scan_ff[`AWSR_SCAN_VREF];
   assign scan_temp_channel       = scan_ff[`AWSR_SCAN_TEMP];

   // ==========================================
   // sampling duration and watch channel decode
   always_comb begin
      unique case (wsc_ff[`AWSR_WSC_SMP])
         3'h0: nxt_smp = `AWSR_SMP_0;
         3'h1: nxt_smp = `AWSR_SMP_1;
         3'h2: nxt_smp = `AWSR_SMP_2;
         3'h3: nxt_smp = `AWSR_SMP_3;
         3'h4: nxt_smp = `AWSR_SMP_4;
         3'h5: nxt_smp = `AWSR_SMP_5;
         3'h6: nxt_smp = `AWSR_SMP_6;
         3'h7: nxt_smp = `AWSR_SMP_7;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         smp_ff <= `AWSR_SMP_0;
      end else begin
         smp_ff <= nxt_smp;
      end
   end

   assign aux_sample_cycles = smp_ff;

   // codes above the last channel are reserved except vref and temp
   assign watch_channel_valid =
      (watch_channel_select <= (MEDIUM_DENSITY ? `AWSR_CH_TOP_MD : `AWSR_CH_TOP)) ||
      (watch_channel_select == `AWSR_CH_VREF) ||
      (watch_channel_select == `AWSR_CH_TEMP);

   // ==========================================
   // depth alignment and window compare
   always_comb begin
      unique case (bit_depth_select)
         AWSR_D12: depth_mask = 12'hFFF;
         AWSR_D10: depth_mask = 12'h3FF;
         AWSR_D8:  depth_mask = 12'h0FF;
         AWSR_D6:  depth_mask = 12'h03F;
      endcase
   end

   assign conv_masked = conv_result & depth_mask;
   assign up_lim      = {uhi_ff, ulo_ff} & depth_mask;
   assign lo_lim      = {lhi_ff, llo_ff} & depth_mask;
   assign watch_hit   = conv_done && !pdn && watch_channel_valid &&
                        (conv_channel == watch_channel_select) &&
                        ((conv_masked > up_lim) || (conv_masked < lo_lim));

   // ==========================================
   // result register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_ff <= 12'h000;
      end else if (conv_done && !pdn) begin
         res_ff <= conv_masked;
      end
   end

   assign result_value = res_ff;

   // ==========================================
   // status flags: hardware set wins over a software clear
   assign flg_wr  = wr_pend_ff && (addr_ff == `AWSR_IDX_FLG);
   assign low_rd  = rd_pend_ff && (addr_ff == `AWSR_IDX_RL);
   assign eoc_set = conv_done && !pdn && (!scan_active || scan_last);
   assign eoc_clr = (flg_wr && !hwdata[`AWSR_FLG_EOC]) || low_rd;
   assign awd_clr = flg_wr && !hwdata[`AWSR_FLG_AWD];
   assign ovr_set = conv_done && !pdn && pend_ff && !dma_ack;
   assign ovr_clr = flg_wr && !hwdata[`AWSR_FLG_OVR];

   assign nxt_eoc = !pdn && (eoc_set || (eoc_ff && !eoc_clr));
   assign nxt_awd = !pdn && (watch_hit || (awd_ff && !awd_clr));
   assign nxt_ovr = !pdn && (ovr_set || (ovr_ff && !ovr_clr));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eoc_ff <= 1'b0;
         awd_ff <= 1'b0;
         ovr_ff <= 1'b0;
      end else begin
         eoc_ff <= nxt_eoc;
         awd_ff <= nxt_awd;
         ovr_ff <= nxt_ovr;
      end
   end

   // ==========================================
   // dma handshake
   // with bypass set a conversion raises no new request; one already pending still waits for dma_ack and can overrun
   assign nxt_pend = !pdn && ((conv_done && !dma_bypass) || (pend_ff && !dma_ack));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   assign dma_request = pend_ff;

   // ==========================================
   // interrupt request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (eoc_ff && ctrl_ff[`AWSR_CTRL_CONVERSION_DONE_IRQ_ENABLE]) ||
                   (awd_ff && ctrl_ff[`AWSR_CTRL_WINDOW_ALARM_IRQ_ENABLE]) ||
                   (ovr_ff && ctrl_ff[`AWSR_CTRL_OVRIE]);
      end
   end

   assign irq_request = irq_ff;

   // ==========================================
   // checks
   AST_SMP_LONGEST: assert property (
      @(posedge ref_clk) disable iff (rst)
      (wsc_ff[7:5] == 3'h7) ##1 (wsc_ff[7:5] == 3'h7) |-> aux_sample_cycles == 9'h180)
      else $error("longest sample code not 384 cycles");

   AST_WATCH_RSVD: assert property (
      @(posedge ref_clk) disable iff (rst)
      (watch_channel_select > 5'h1D) |-> !watch_channel_valid)
      else $error("reserved watch code accepted");

   AST_OVR_SET: assert property (
      @(posedge ref_clk) disable iff (rst)
      conv_done && converter_power_on && dma_request && !dma_ack |=> ovr_ff)
      else $error("overrun not flagged");

   AST_OVR_PDN: assert property (
      @(posedge ref_clk) disable iff (rst)
      !converter_power_on |=> !ovr_ff && !dma_request)
      else $error("overrun survives power-down");

   AST_AWD_SET: assert property (
      @(posedge ref_clk) disable iff (rst)
      conv_done && converter_power_on && watch_channel_valid &&
      conv_channel == watch_channel_select &&
      (conv_masked > up_lim) |=> awd_ff)
      else $error("alarm not raised above upper limit");

   AST_AWD_PDN: assert property (
      @(posedge ref_clk) disable iff (rst)
      !converter_power_on ##1 !converter_power_on |-> !awd_ff)
      else $error("alarm set during power-down");

   AST_EOC_SCAN: assert property (
      @(posedge ref_clk) disable iff (rst)
      !eoc_ff && scan_active && !scan_last |=> !eoc_ff)
      else $error("done flag set before last scan channel");

   AST_EOC_READ: assert property (
      @(posedge ref_clk) disable iff (rst)
      rd_pend_ff && addr_ff == `AWSR_IDX_RL && !conv_done |=> !eoc_ff && hreadyout)
      else $error("low result read did not clear done flag");

   AST_RES_D8: assert property (
      @(posedge ref_clk) disable iff (rst)
      conv_done && converter_power_on && bit_depth_select == 2'b10 |=>
      result_value[11:8] == 4'h0 && result_value[7:0] == $past(conv_result[7:0]))
      else $error("8-bit result misaligned");

   AST_FLG_RSVD: assert property (
      @(posedge ref_clk) disable iff (rst)
      rd_pend_ff && addr_ff == `AWSR_IDX_FLG |=> hrdata[31:3] == 29'h0000_0000)
      else $error("reserved status bits not zero");

   AST_IRQ: assert property (
      @(posedge ref_clk) disable iff (rst)
      eoc_ff && ctrl_ff[`AWSR_CTRL_CONVERSION_DONE_IRQ_ENABLE] |=> irq_request)
      else $error("interrupt not raised");

   AST_WR_ONE: assert property (
      @(posedge ref_clk) disable iff (rst)
      flg_wr && hwdata[2] && ovr_ff && converter_power_on |=> ovr_ff)
      else $error("writing one cleared overrun");

endmodule

//--- inc/awsr_cfg.svh
// offsets, field positions, reset values and timing counts of the watchdog/status block
`ifndef AWSR_CFG_SVH
`define AWSR_CFG_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define AWSR_IDX_CTRL 6'h00
`define AWSR_IDX_WSC  6'h02
`define AWSR_IDX_FLG  6'h03
`define AWSR_IDX_RH   6'h04
`define AWSR_IDX_RL   6'h05
`define AWSR_IDX_UHI  6'h06
`define AWSR_IDX_ULO  6'h07
`define AWSR_IDX_LHI  6'h08
`define AWSR_IDX_LLO  6'h09
`define AWSR_IDX_SCAN 6'h0A

// ==========================================
// reset values
`define AWSR_RST_CTRL 8'h00
`define AWSR_RST_WSC  8'h1F
`define AWSR_RST_UHI  4'hF
`define AWSR_RST_ULO  8'hFF
`define AWSR_RST_LHI  4'h0
`define AWSR_RST_LLO  8'h00
`define AWSR_RST_SCAN 8'h00

// ==========================================
// field positions
`define AWSR_CTRL_PON   0
`define AWSR_CTRL_CONVERSION_DONE_IRQ_ENABLE 3
`define AWSR_CTRL_WINDOW_ALARM_IRQ_ENABLE 4
`define AWSR_CTRL_RES   6:5
`define AWSR_CTRL_OVRIE 7
`define AWSR_WSC_SMP    7:5
`define AWSR_WSC_CHAN   4:0
`define AWSR_FLG_EOC    0
`define AWSR_FLG_AWD    1
`define AWSR_FLG_OVR    2
`define AWSR_SCAN_DMAOF 7
`define AWSR_SCAN_TEMP  5
`define AWSR_SCAN_VREF  4

// ==========================================
// watch channel codes
`define AWSR_CH_TOP_MD 5'h18
`define AWSR_CH_TOP    5'h1B
`define AWSR_CH_VREF   5'h1C
`define AWSR_CH_TEMP   5'h1D

// ==========================================
// sampling durations in converter clock cycles
`define AWSR_SMP_0 9'h004
`define AWSR_SMP_1 9'h009
`define AWSR_SMP_2 9'h010
`define AWSR_SMP_3 9'h018
`define AWSR_SMP_4 9'h030
`define AWSR_SMP_5 9'h060
`define AWSR_SMP_6 9'h0C0
`define AWSR_SMP_7 9'h180

`endif

//--- inc/awsr_pkg.sv
// types shared by the watchdog/status block
package awsr_pkg;

   // ==========================================
   // result width selection
   typedef enum logic [1:0] {
      AWSR_D12 = 2'b00,
      AWSR_D10 = 2'b01,
      AWSR_D8  = 2'b10,
      AWSR_D6  = 2'b11
   } awsr_depth_t;

   typedef logic [11:0] awsr_value_t;

endpackage

//--- verif/awsr_dma_model.sv
// dma controller stand-in that fetches each waiting result
`timescale 1ns/1ps

module awsr_dma_model #(
   parameter int DELAY = 2
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // handshake
   input  wire logic dma_request,
   input  wire logic enable,
   output logic      dma_ack
);
   int cnt_ff;

   // ==========
   // fetch
   // a held-off controller leaves the result unread, which is how overrun is provoked
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_ff  <= 0;
         dma_ack <= 1'b0;
      end else if (dma_request && enable && !dma_ack) begin
         dma_ack <= (cnt_ff == DELAY);
         cnt_ff  <= (cnt_ff == DELAY) ? 0 : cnt_ff + 1;
      end else begin
         dma_ack <= 1'b0;
         cnt_ff  <= 0;
      end
   end
endmodule

//--- verif/tb.sv
// self-checking bench for the watchdog/status register block
`timescale 1ns/1ps

module tb;
   logic        ref_clk, rst, hsel, hwrite, hready, conv_done;
   logic        scan_active, scan_last, dma_ack, dma_en;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, rd;
   logic [4:0]  conv_channel;
   logic [11:0] conv_result;
   wire  [31:0] hrdata;
   wire         hreadyout, dma_request, dma_bypass, watch_channel_valid, irq_request;
   wire  [8:0]  aux_sample_cycles;
   wire  [3:0]  scan_channel_bits, md_scan;
   wire         hresp, converter_power_on, scan_internal_reference, scan_temp_channel, md_valid;
   wire  [1:0]  bit_depth_select;
   wire  [4:0]  watch_channel_select;
   wire  [11:0] result_value;
   int          n_errors, n_compared;
   // row: write bit 22, index 21:16, write data 15:8, expected read 7:0
   logic [22:0] rows [21] = '{
      23'h409900,
      23'h02001F, 23'h030000, 23'h040000, 23'h050000, 23'h06000F, 23'h0700FF,
      23'h080000, 23'h090000, 23'h0A0000, 23'h46FA00, 23'h06000A, 23'h483500,
      23'h080005, 23'h495A00, 23'h09005A, 23'h43FF00, 23'h030000,
      23'h4A4F00,
      23'h0A000F, 23'h3F0000};
   logic [8:0]  smp [8] = '{9'h004, 9'h009, 9'h010, 9'h018, 9'h030, 9'h060, 9'h0C0, 9'h180};

   assign hready = hreadyout;

   awsr_regs u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hreadyout, .hrdata, .hresp, .conv_done, .conv_channel, .conv_result,
      .scan_active, .scan_last, .dma_ack, .dma_request, .dma_bypass, .converter_power_on,
      .bit_depth_select, .aux_sample_cycles, .watch_channel_select, .watch_channel_valid,
      .scan_channel_bits, .scan_internal_reference, .scan_temp_channel, .result_value,
      .irq_request);

   // medium-density twin shares the bus, only its watch channel decode and scan channel bits are looked at
   awsr_regs #(.MEDIUM_DENSITY(1'b1)) u_dut_md (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hreadyout(), .hrdata(), .hresp(), .conv_done, .conv_channel,
      .conv_result, .scan_active, .scan_last, .dma_ack, .dma_request(), .dma_bypass(),
      .converter_power_on(), .bit_depth_select(), .aux_sample_cycles(), .watch_channel_select(),
      .watch_channel_valid(md_valid), .scan_channel_bits(md_scan), .scan_internal_reference(),
      .scan_temp_channel(), .result_value(), .irq_request());

   awsr_dma_model u_dma (.ref_clk, .rst, .dma_request, .enable(dma_en), .dma_ack);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ==========
   // tasks
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdc(input string nm, input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(nm, rd, exp);
   endtask

   task automatic conv(input logic [4:0] ch, input logic [11:0] v, input logic sa, sl);
      @(posedge ref_clk);
      conv_done    <= 1'b1;
      conv_channel <= ch;
      conv_result  <= v;
      scan_active  <= sa;
      scan_last    <= sl;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========
   // watchdog
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      finish_test();
   end

   // ==========
   // sequence
   initial begin
      {rst, hsel, hwrite, conv_done, scan_active, scan_last, dma_en} = 7'b1000000;
      {haddr, htrans, hwdata, conv_channel, conv_result} = '0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         bus(rows[i][22], rows[i][21:16], rows[i][15:8]);
         if (!rows[i][22]) begin
            chk("register", rd, {24'h0, rows[i][7:0]});
         end
      end
      chk("scan bits", 32'(scan_channel_bits), 32'hF);
      chk("md scan bits", 32'(md_scan), 32'h1);
      chk("scan vref", 32'(scan_internal_reference), 32'h0);
      chk("scan temp", 32'(scan_temp_channel), 32'h0);
      chk("power on", 32'(converter_power_on), 32'h1);
      chk("response", 32'(hresp), 32'h0);
      $display("test register table done");
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 6'h02, {i[2:0], 5'h05});
         repeat (2) @(posedge ref_clk);
         chk("sample cycles", 32'(aux_sample_cycles), 32'(smp[i]));
      end
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 6'h02, 8'h1B + 8'(i));
         @(posedge ref_clk);
         chk("watch valid", 32'(watch_channel_valid), 32'(i < 3));
         chk("md watch valid", 32'(md_valid), 32'(i == 1 || i == 2));
      end
      $display("test selects done");
      // window is 0x55A..0xAFF on channel 5, dma held off
      bus(1'b1, 6'h02, 8'h05);
      conv(5'h05, 12'hB00, 1'b0, 1'b0);
      chk("watch select", 32'(watch_channel_select), 32'h05);
      chk("dma request", 32'(dma_request), 32'h1);
      chk("irq", 32'(irq_request), 32'h1);
      rdc("flags", 6'h03, 32'h03);
      rdc("result high", 6'h04, 32'h0B);
      rdc("result low", 6'h05, 32'h00);
      rdc("flags", 6'h03, 32'h02);
      conv(5'h07, 12'h600, 1'b0, 1'b0);
      rdc("flags", 6'h03, 32'h07);
      bus(1'b1, 6'h03, 8'hFD);
      rdc("flags", 6'h03, 32'h05);
      dma_en <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk("dma request", 32'(dma_request), 32'h0);
      bus(1'b1, 6'h03, 8'h00);
      conv(5'h05, 12'h55A, 1'b0, 1'b0);
      rdc("flags", 6'h03, 32'h01);
      conv(5'h05, 12'h559, 1'b0, 1'b0);
      rdc("flags", 6'h03, 32'h03);
      bus(1'b1, 6'h00, 8'h98);
      rdc("flags", 6'h03, 32'h00);
      chk("irq", 32'(irq_request), 32'h0);
      conv(5'h05, 12'hB00, 1'b0, 1'b0);
      rdc("flags", 6'h03, 32'h00);
      $display("test flags done");
      bus(1'b1, 6'h00, 8'h01);
      conv(5'h00, 12'h123, 1'b1, 1'b0);
      rdc("flags", 6'h03, 32'h00);
      conv(5'h01, 12'h124, 1'b1, 1'b1);
      rdc("flags", 6'h03, 32'h01);
      $display("test scan done");
      bus(1'b1, 6'h00, 8'h61);
      conv(5'h02, 12'hFFF, 1'b0, 1'b0);
      chk("depth", 32'(bit_depth_select), 32'h3);
      chk("result", 32'(result_value), 32'h03F);
      rdc("result high", 6'h04, 32'h00);
      rdc("result low", 6'h05, 32'h3F);
      bus(1'b1, 6'h00, 8'h21);
      conv(5'h02, 12'hFFF, 1'b0, 1'b0);
      rdc("result high", 6'h04, 32'h03);
      rdc("result low", 6'h05, 32'hFF);
      bus(1'b1, 6'h00, 8'h41);
      bus(1'b1, 6'h03, 8'h00);
      conv(5'h05, 12'h0F0, 1'b0, 1'b0);
      rdc("flags", 6'h03, 32'h01);
      bus(1'b1, 6'h00, 8'h01);
      bus(1'b1, 6'h03, 8'h00);
      conv(5'h05, 12'h0F0, 1'b0, 1'b0);
      rdc("flags", 6'h03, 32'h03);
      $display("test depth done");
      bus(1'b1, 6'h0A, 8'h8F);
      @(posedge ref_clk);
      chk("bypass", 32'(dma_bypass), 32'h1);
      conv(5'h01, 12'h010, 1'b0, 1'b0);
      chk("dma request", 32'(dma_request), 32'h0);
      $display("test bypass done");
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rdc("watch sample", 6'h02, 32'h1F);
      rdc("upper low", 6'h07, 32'hFF);
      rdc("scan", 6'h0A, 32'h00);
      $display("test reset done");
      finish_test();
   end
endmodule
